// file: hdl/char_stream_if.sv
// Valid and ready stream of received characters between the buffer and its neighbours.
`timescale 1ns/1ns
interface char_stream_if #(parameter int WIDTH = 9);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: hdl/ir_codec.sv
// Infrared pulse encoder and decoder running on the sixteen-times baud tick.
`timescale 1ns/1ns
`include "uart_aux_regs.svh"
module ir_codec (
   input  logic clk,
   input  logic rst_n,
   input  logic baud16_tick,
   input  logic tx_bit_start,
   input  logic tx_bit,
   input  logic rx_level,
   input  logic rx_invert,
   output logic ir_tx,
   output logic ir_rx_bit
);
   logic       bit_ff;
   logic [3:0] phase_ff;
   logic [3:0] hold_ff;
   logic       dec_ff;
   logic [3:0] hi_ticks_ff;
   wire        rx_pulse;

   assign ir_tx     = !bit_ff && (phase_ff >= `IR_PULSE_FIRST) && (phase_ff <= `IR_PULSE_LAST);
   assign rx_pulse  = rx_invert ? !rx_level : rx_level;
   assign ir_rx_bit = dec_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_ff   <= 1'b1;
         phase_ff <= `IR_PHASE_IDLE;
      end else if (tx_bit_start) begin
         bit_ff   <= tx_bit;
         phase_ff <= 4'h0;
      end else if (baud16_tick && phase_ff != `IR_PHASE_IDLE) begin
         phase_ff <= phase_ff + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ff <= 4'h0;
         dec_ff  <= 1'b1;
      end else if (baud16_tick) begin
         if (rx_pulse) begin
            hold_ff <= `IR_HOLD_TICKS;
            dec_ff  <= 1'b0;
         end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
         end else begin
            dec_ff  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) hi_ticks_ff <= 4'h0;
      else if (!ir_tx) hi_ticks_ff <= 4'h0;
      else if (baud16_tick) hi_ticks_ff <= hi_ticks_ff + 4'h1;
   end

   a_ir_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(ir_tx) && !$past(tx_bit_start) |-> $past(hi_ticks_ff) == 4'h2)
      else $error("Infrared pulse is not three ticks wide.");

   a_ir_one_dark: assert property (@(posedge clk) disable iff (!rst_n)
      bit_ff |-> !ir_tx)
      else $error("Infrared pulse sent for a one bit.");

   a_ir_rx_decode: assert property (@(posedge clk) disable iff (!rst_n)
      baud16_tick && rx_pulse |=> !ir_rx_bit)
      else $error("Light pulse not decoded as a zero.");
endmodule

// file: hdl/rx_char_buf.sv
// Two-entry buffer that holds received characters while the receive FIFO stalls.
`timescale 1ns/1ns
module rx_char_buf #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  logic          clk,
   input  logic          rst_n,
   char_stream_if.snk    in_s,
   char_stream_if.src    out_s
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [PW:0]      count_ff;
   wire              push;
   wire              pop;

   assign in_s.ready  = (count_ff != (PW+1)'(DEPTH));
   assign out_s.valid = (count_ff != '0);
   assign out_s.data  = store_ff[rd_ptr_ff];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
         count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) store_ff[wr_ptr_ff] <= in_s.data;
   end

   a_buf_full_stall: assert property (@(posedge clk) disable iff (!rst_n)
      (count_ff == (PW+1)'(DEPTH)) |-> !in_s.ready)
      else $error("Buffer accepts a word while full.");
endmodule

// file: hdl/uart_aux_line.sv
// Auxiliary line features of one channel: detect, direction, infrared, sleep, loopback.
`timescale 1ns/1ns
`include "uart_aux_regs.svh"
module uart_aux_line (
   input  logic       clk,
   input  logic       rst_n,
   input  logic       baud16_tick,
   input  logic [7:0] second_pause_char,
   input  logic       special_char_en,
   input  logic [1:0] word_len,
   input  logic       parity_en,
   input  logic       two_stop_bits,
   input  logic       half_duplex_en,
   input  logic       direction_invert,
   input  logic       ir_en,
   input  logic       ir_rx_invert,
   input  logic       loopback_en,
   input  logic       sleep_en,
   input  logic       int_pending,
   input  logic [3:0] modem_delta,
   input  logic       peer_sleep_en,
   input  logic       peer_int_pending,
   input  logic [3:0] peer_modem_delta,
   input  logic       peer_rx_pin,
   input  logic       tx_hold_write,
   input  logic       tx_fifo_empty,
   input  logic       tx_shift_busy,
   input  logic       tx_bit_start,
   input  logic       tx_shift_bit,
   input  logic       core_rts_n,
   input  logic       core_dtr_n,
   input  logic       rx_char_valid,
   input  logic [7:0] rx_char,
   input  logic       rx_fifo_ready,
   input  logic       rx_trigger_reached,
   input  logic       rx_pin,
   input  logic       cts_n_pin,
   input  logic       dsr_n_pin,
   input  logic       cd_n_pin,
   input  logic       ri_n_pin,
   output logic       tx_pin,
   output logic       rts_n_pin,
   output logic       dtr_n_pin,
   output logic       rx_shift_in,
   output logic [3:0] modem_in_n,
   output logic       auto_flow_allowed,
   output logic       rx_char_ready,
   output logic       rx_fifo_valid,
   output logic [7:0] rx_fifo_data,
   output logic       special_detect_set,
   output logic       send_pause_char,
   output logic       osc_run,
   output logic       sleeping
);
   char_stream_if #(.WIDTH(9)) buf_in();
   char_stream_if #(.WIDTH(9)) buf_out();

   logic                           special_detect_ff;
   logic                           dir_active_ff;
   logic                           pause_pend_ff;
   logic [8:0]                     pause_cnt_ff;
   logic                           trig_ff;
   logic [3:0]                     modem_last_ff;
   logic                           rx_last_ff;
   uart_aux_pkg::power_state_type  pwr_ff;
   uart_aux_pkg::power_state_type  nxt_pwr;

   wire [7:0] cmp_mask;
   wire       char_match;
   wire       ir_tx;
   wire       ir_rx_bit;
   wire       direction_n;
   wire [3:0] modem_pins;
   wire       sleep_ok;
   wire       wake;
   wire [8:0] pause_ticks;

   assign cmp_mask   = uart_aux_pkg::char_mask(word_len);
   // Special character compare, bit zero first received.
   // Bit zero meets first received bit.
   assign char_match = special_char_en && (((rx_char ^ second_pause_char) & cmp_mask) == 8'h00);

   // Matched character still goes to the FIFO.
   assign buf_in.valid       = rx_char_valid;
   assign buf_in.data        = {char_match, rx_char};
   assign rx_char_ready      = buf_in.ready;
   assign buf_out.ready      = rx_fifo_ready;
   assign rx_fifo_valid      = buf_out.valid;
   assign rx_fifo_data       = buf_out.data[7:0];
   assign special_detect_set = special_detect_ff;

   rx_char_buf #(.WIDTH(9), .DEPTH(2)) u_rx_buf (
      .clk   (clk),
      .rst_n (rst_n),
      .in_s  (buf_in),
      .out_s (buf_out)
   );

   // Detection pulse on the shared status bit.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) special_detect_ff <= 1'b0;
      else special_detect_ff <= buf_out.valid && buf_out.ready && buf_out.data[8];
   end

   ir_codec u_ir (
      .clk          (clk),
      .rst_n        (rst_n),
      .baud16_tick  (baud16_tick),
      .tx_bit_start (tx_bit_start),
      .tx_bit       (tx_shift_bit),
      .rx_level     (rx_pin),
      .rx_invert    (ir_rx_invert),
      .ir_tx        (ir_tx),
      .ir_rx_bit    (ir_rx_bit)
   );

   // Direction active while data waits or shifts.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) dir_active_ff <= 1'b0;
      else dir_active_ff <= tx_shift_busy || !tx_fifo_empty;
   end

   // Asserted low one clock after the FIFO holds data.
   // Polarity inversion of the direction output.
   assign direction_n = (dir_active_ff ? 1'b0 : 1'b1) ^ direction_invert;

   // Outputs held and modem inputs ignored in loopback.
   assign tx_pin     = loopback_en ? !ir_en : (ir_en ? ir_tx : tx_shift_bit);
   assign rts_n_pin  = loopback_en ? 1'b1 : (half_duplex_en ? direction_n : core_rts_n);
   assign dtr_n_pin  = loopback_en ? 1'b1 : core_dtr_n;
   assign modem_pins = {cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin};
   assign modem_in_n = loopback_en ? `MODEM_PINS_IDLE : modem_pins;

   // Transmit shift output looped into the receiver.
   // Infrared decoder feeds the receiver when enabled.
   assign rx_shift_in = loopback_en ? tx_shift_bit : (ir_en ? ir_rx_bit : rx_pin);

   // Automatic flow control off in loopback.
   assign auto_flow_allowed = !loopback_en;

   // Two character times in sixteen-times ticks.
   assign pause_ticks = 9'(`PAUSE_CHARS) *
                        {1'b0, uart_aux_pkg::frame_bits(word_len, parity_en, two_stop_bits),
                         4'h0};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_ff       <= 1'b0;
         pause_pend_ff <= 1'b0;
         pause_cnt_ff  <= `PAUSE_CNT_RESET;
      end else begin
         trig_ff <= rx_trigger_reached;
         if (rx_trigger_reached && !trig_ff) begin
            pause_pend_ff <= 1'b1;
            pause_cnt_ff  <= pause_ticks;
         end else if (pause_pend_ff && baud16_tick) begin
            if (pause_cnt_ff == 9'h001) pause_pend_ff <= 1'b0;
            pause_cnt_ff <= pause_cnt_ff - 9'h001;
         end
      end
   end

   assign send_pause_char = pause_pend_ff && baud16_tick && (pause_cnt_ff == 9'h001);

   // Sleep entry condition across both channels.
   assign sleep_ok = !int_pending && !peer_int_pending && sleep_en && peer_sleep_en &&
                     (modem_delta == `MODEM_DELTA_NONE) &&
                     (peer_modem_delta == `MODEM_DELTA_NONE) && rx_pin && peer_rx_pin;

   // Wake sources, combinational so they act with the clock stopped.
   assign wake = (rx_last_ff && !rx_pin) || tx_hold_write || (modem_pins != modem_last_ff);

   // Stays automatic until sleep enable clears.
   always_comb begin
      case (pwr_ff)
         uart_aux_pkg::PWR_AWAKE:
            nxt_pwr = (sleep_ok && !wake) ? uart_aux_pkg::PWR_ASLEEP : uart_aux_pkg::PWR_AWAKE;
         uart_aux_pkg::PWR_ASLEEP:
            nxt_pwr = (wake || !sleep_ok) ? uart_aux_pkg::PWR_AWAKE : uart_aux_pkg::PWR_ASLEEP;
         default:
            nxt_pwr = uart_aux_pkg::PWR_AWAKE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_ff        <= uart_aux_pkg::PWR_AWAKE;
         modem_last_ff <= `MODEM_PINS_IDLE;
         rx_last_ff    <= 1'b1;
      end else begin
         pwr_ff        <= nxt_pwr;
         modem_last_ff <= modem_pins;
         rx_last_ff    <= rx_pin;
      end
   end

   assign sleeping = (pwr_ff == uart_aux_pkg::PWR_ASLEEP);
   assign osc_run  = !sleeping || wake;

   a_match_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
      buf_out.valid && rx_fifo_ready && buf_out.data[8] |=> special_detect_set)
      else $error("Special character match did not set detection.");

   a_match_five_bits: assert property (@(posedge clk) disable iff (!rst_n)
      special_char_en && word_len == 2'b00 && rx_char[4:0] == second_pause_char[4:0]
      |-> char_match)
      else $error("Upper bits took part in a five-bit compare.");

   a_detect_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      !special_char_en |-> !char_match)
      else $error("Match reported while detection disabled.");

   sequence dir_idle_s;
      half_duplex_en && !loopback_en && !direction_invert && !tx_shift_busy && tx_fifo_empty
      ##1 half_duplex_en && !loopback_en && !direction_invert;
   endsequence

   sequence dir_loaded_s;
      half_duplex_en && !loopback_en && !direction_invert && !tx_fifo_empty
      ##1 half_duplex_en && !loopback_en && !direction_invert;
   endsequence

   sequence wake_up_s;
      osc_run ##1 !sleeping;
   endsequence

   a_dir_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
      dir_idle_s |-> rts_n_pin)
      else $error("Direction not released after last stop bit.");

   a_dir_before_start: assert property (@(posedge clk) disable iff (!rst_n)
      dir_loaded_s |-> !rts_n_pin)
      else $error("Direction not asserted with data waiting.");

   a_dir_inverted: assert property (@(posedge clk) disable iff (!rst_n)
      half_duplex_en && !loopback_en && direction_invert |-> rts_n_pin == dir_active_ff)
      else $error("Direction output not inverted.");

   a_loop_pins_held: assert property (@(posedge clk) disable iff (!rst_n)
      loopback_en |-> rts_n_pin && dtr_n_pin && modem_in_n == `MODEM_PINS_IDLE)
      else $error("Loopback does not hold pins.");

   a_loop_data_path: assert property (@(posedge clk) disable iff (!rst_n)
      loopback_en |-> rx_shift_in == tx_shift_bit && !auto_flow_allowed)
      else $error("Loopback path or flow control wrong.");

   a_no_sleep_int: assert property (@(posedge clk) disable iff (!rst_n)
      int_pending || peer_int_pending |=> !sleeping)
      else $error("Sleep entered with interrupt pending.");

   a_wake_on_write: assert property (@(posedge clk) disable iff (!rst_n)
      sleeping && tx_hold_write |-> wake_up_s)
      else $error("Transmit write did not wake the device.");

   a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
      !sleeping && sleep_ok && !wake |=> sleeping ##0 !osc_run || wake)
      else $error("Sleep not entered with all conditions met.");

   a_pause_delay: assert property (@(posedge clk) disable iff (!rst_n)
      rx_trigger_reached && !trig_ff |=> pause_cnt_ff == $past(pause_ticks) && pause_pend_ff)
      else $error("Pause delay not loaded at trigger.");

   a_sleep_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      !sleep_en |=> !sleeping)
      else $error("Sleep held with sleep enable cleared.");

   a_ir_tx_route: assert property (@(posedge clk) disable iff (!rst_n)
      ir_en && !loopback_en |-> tx_pin == ir_tx)
      else $error("Infrared encoder not on the transmit pin.");
endmodule

// file: hdl/uart_aux_pkg.sv
// Types and helper functions shared by the auxiliary line feature modules.
package uart_aux_pkg;

   typedef enum logic [1:0] {
      WLEN_5 = 2'b00,
      WLEN_6 = 2'b01,
      WLEN_7 = 2'b10,
      WLEN_8 = 2'b11
   } word_len_type;

   typedef enum logic {
      PWR_AWAKE  = 1'b0,
      PWR_ASLEEP = 1'b1
   } power_state_type;

   // Returns the mask of the character bits that the word length uses.
   function automatic logic [7:0] char_mask(input logic [1:0] word_len);
      case (word_len)
         WLEN_5:  char_mask = 8'h1F;
         WLEN_6:  char_mask = 8'h3F;
         WLEN_7:  char_mask = 8'h7F;
         default: char_mask = 8'hFF;
      endcase
   endfunction

   // Returns the bits in one character frame: start, data, parity and stop bits.
   function automatic logic [3:0] frame_bits(input logic [1:0] word_len,
                                             input logic       parity_en,
                                             input logic       two_stop);
      frame_bits = 4'h7 + {2'h0, word_len} + {3'h0, parity_en} + {3'h0, two_stop};
   endfunction

endpackage

// file: hdl/uart_aux_regs.svh
// Timing counts, idle codes and reset values of the auxiliary line features.
`ifndef UART_AUX_REGS_SVH
`define UART_AUX_REGS_SVH

`define IR_PULSE_FIRST      4'h7
`define IR_PULSE_LAST       4'h9
`define IR_PHASE_IDLE       4'hF
`define IR_HOLD_TICKS       4'hF
`define TICKS_PER_BIT       5'h10
`define PAUSE_CHARS         2'h2
`define CHAR_FRAME_BITS     4'h7
`define MODEM_DELTA_NONE    4'h0
`define MODEM_PINS_IDLE     4'hF
`define PAUSE_CNT_RESET     9'h000

`endif

// file: verification/remote_line_model.sv
// Far-side line model: receive and modem pins, and timing of infrared transmit pulses.
`timescale 1ns/1ns
module remote_line_model (
   input  logic       clk,
   input  logic       ir_mode,
   input  logic       loopback_en,
   input  logic       rx_level,
   input  logic [3:0] modem_level_n,
   input  logic       tx_pin,
   output logic       rx_pin,
   output logic       cts_n_pin,
   output logic       dsr_n_pin,
   output logic       cd_n_pin,
   output logic       ri_n_pin,
   output logic [7:0] pulse_cycles,
   output logic [7:0] pulse_count
);
   logic [7:0] width_ff = 8'h00;

   initial begin
      pulse_cycles = 8'h00;
      pulse_count = 8'h00;
   end

   assign rx_pin = loopback_en ? 1'b1 : rx_level;
   assign {cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin} = modem_level_n;

   // Measures each high pulse on the transmit pin while infrared mode is on.
   always @(posedge clk) begin
      if (!ir_mode) begin
         width_ff <= 8'h00;
         pulse_count <= 8'h00;
      end else if (tx_pin === 1'b1) begin
         width_ff <= width_ff + 8'h01;
      end else if (width_ff != 8'h00) begin
         pulse_cycles <= width_ff;
         pulse_count <= pulse_count + 8'h01;
         width_ff <= 8'h00;
      end
   end
endmodule

// file: verification/tb.sv
// Testbench for the auxiliary line features of one channel.
`timescale 1ns/1ns
module tb;
   logic        clk = 1'b0, rst_n = 1'b0, bit_req = 1'b0, cnt_on = 1'b0, rx_lvl = 1'b1;
   logic [1:0]  tc = 2'h0, word_len = 2'h3;
   logic [7:0]  second_pause_char = 8'hB6, rx_char = 8'h00, pat;
   logic [3:0]  modem_delta = 4'h0, peer_modem_delta = 4'h0, modem_lvl_n = 4'hF;
   logic        special_char_en = 1'b0, parity_en = 1'b0, two_stop_bits = 1'b0;
   logic        half_duplex_en = 1'b0, direction_invert = 1'b0, ir_en = 1'b0;
   logic        ir_rx_invert = 1'b0, loopback_en = 1'b0, sleep_en = 1'b0;
   logic        int_pending = 1'b0, peer_sleep_en = 1'b0, peer_int_pending = 1'b0;
   logic        peer_rx_pin = 1'b1, tx_hold_write = 1'b0, tx_fifo_empty = 1'b1;
   logic        tx_shift_busy = 1'b0, tx_shift_bit = 1'b1, core_rts_n = 1'b1;
   logic        core_dtr_n = 1'b1, rx_char_valid = 1'b0, rx_fifo_ready = 1'b0;
   logic        rx_trigger_reached = 1'b0, baud16_tick, tx_bit_start, rx_pin;
   logic        cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin, tx_pin, rts_n_pin, dtr_n_pin;
   logic        rx_shift_in, auto_flow_allowed, rx_char_ready, rx_fifo_valid;
   logic        special_detect_set, send_pause_char, osc_run, sleeping;
   logic [3:0]  modem_in_n;
   logic [7:0]  rx_fifo_data, p_cyc, p_cnt;
   logic [15:0] ticks = 16'h0000, p_ticks = 16'h0000;
   int          miscompares = 0, check_count = 0, cycles = 0;

   uart_aux_line uut (
      .clk(clk), .rst_n(rst_n), .baud16_tick(baud16_tick),
      .second_pause_char(second_pause_char), .special_char_en(special_char_en),
      .word_len(word_len), .parity_en(parity_en), .two_stop_bits(two_stop_bits),
      .half_duplex_en(half_duplex_en), .direction_invert(direction_invert), .ir_en(ir_en),
      .ir_rx_invert(ir_rx_invert), .loopback_en(loopback_en), .sleep_en(sleep_en),
      .int_pending(int_pending), .modem_delta(modem_delta), .peer_sleep_en(peer_sleep_en),
      .peer_int_pending(peer_int_pending), .peer_modem_delta(peer_modem_delta),
      .peer_rx_pin(peer_rx_pin), .tx_hold_write(tx_hold_write), .tx_fifo_empty(tx_fifo_empty),
      .tx_shift_busy(tx_shift_busy), .tx_bit_start(tx_bit_start), .tx_shift_bit(tx_shift_bit),
      .core_rts_n(core_rts_n), .core_dtr_n(core_dtr_n), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rx_fifo_ready(rx_fifo_ready), .rx_trigger_reached(rx_trigger_reached),
      .rx_pin(rx_pin), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin), .cd_n_pin(cd_n_pin),
      .ri_n_pin(ri_n_pin), .tx_pin(tx_pin), .rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin),
      .rx_shift_in(rx_shift_in), .modem_in_n(modem_in_n), .auto_flow_allowed(auto_flow_allowed),
      .rx_char_ready(rx_char_ready), .rx_fifo_valid(rx_fifo_valid), .rx_fifo_data(rx_fifo_data),
      .special_detect_set(special_detect_set), .send_pause_char(send_pause_char),
      .osc_run(osc_run), .sleeping(sleeping)
   );

   remote_line_model peer (
      .clk(clk), .ir_mode(ir_en), .loopback_en(loopback_en), .rx_level(rx_lvl),
      .modem_level_n(modem_lvl_n), .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin),
      .dsr_n_pin(dsr_n_pin), .cd_n_pin(cd_n_pin), .ri_n_pin(ri_n_pin),
      .pulse_cycles(p_cyc), .pulse_count(p_cnt)
   );

   always #5 clk = ~clk;
   always @(negedge clk) tc <= tc + 2'h1;
   assign baud16_tick = (tc == 2'h0);
   assign tx_bit_start = baud16_tick & bit_req;

   // Counts baud ticks from the trigger and the timeout ceiling.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cnt_on) ticks <= ticks + {15'h0000, baud16_tick};
      if (cnt_on && send_pause_char) p_ticks <= ticks + {15'h0000, baud16_tick};
      if (cycles == 10000) begin
         miscompares = miscompares + 1;
         close_out();
      end
   end

   task automatic close_out;
      $display("check_count=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic push(input logic [7:0] c);
      rx_char_valid = 1'b1;
      rx_char = c;
      while (rx_char_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask

   task automatic pop(input logic [7:0] d, input logic det);
      @(negedge clk);
      chk(rx_fifo_valid, 1'h1);
      chk(rx_fifo_data, d);
      rx_fifo_ready = 1'b1;
      @(negedge clk);
      rx_fifo_ready = 1'b0;
      chk(special_detect_set, det);
   endtask

   task automatic irbit(input logic b);
      tx_shift_bit = b;
      do begin
         @(negedge clk);
         #1;
      end while (tc != 2'h3);
      @(negedge clk);
      bit_req = 1'b1;
      @(negedge clk);
      bit_req = 1'b0;
      cyc(64);
   endtask

   initial begin
      cyc(8);
      rst_n = 1'b1;
      chk({sleeping, osc_run}, 2'h1);
      for (int w = 0; w < 5; w++) begin
         word_len = w[1:0];
         special_char_en = (w < 4);
         pat = (8'hB6 & (8'hFF >> (3 - w[1:0]))) | (8'h49 & ~(8'hFF >> (3 - w[1:0])));
         push(pat);
         push(8'hB7);
         rx_char_valid = 1'b0;
         chk(rx_char_ready, 1'h0);
         pop(pat, (w < 4));
         pop(8'hB7, 1'b0);
      end
      half_duplex_en = 1'b1;
      cyc(2);
      chk(rts_n_pin, 1'h1);
      tx_fifo_empty = 1'b0;
      cyc(1);
      chk(rts_n_pin, 1'h0);
      direction_invert = 1'b1;
      #1;
      chk(rts_n_pin, 1'h1);
      cyc(1);
      tx_fifo_empty = 1'b1;
      tx_shift_busy = 1'b1;
      cyc(2);
      chk(rts_n_pin, 1'h1);
      tx_shift_busy = 1'b0;
      cyc(1);
      chk(rts_n_pin, 1'h0);
      direction_invert = 1'b0;
      half_duplex_en = 1'b0;
      ir_en = 1'b1;
      rx_lvl = 1'b0;
      cyc(2);
      chk(tx_pin, 1'h0);
      irbit(1'b0);
      chk(p_cyc, 8'h0C);
      irbit(1'b1);
      chk(p_cnt, 8'h01);
      chk(rx_shift_in, 1'h1);
      rx_lvl = 1'b1;
      cyc(4);
      rx_lvl = 1'b0;
      cyc(4);
      chk(rx_shift_in, 1'h0);
      cyc(80);
      chk(rx_shift_in, 1'h1);
      ir_rx_invert = 1'b1;
      rx_lvl = 1'b1;
      cyc(80);
      chk(rx_shift_in, 1'h1);
      rx_lvl = 1'b0;
      cyc(4);
      rx_lvl = 1'b1;
      cyc(4);
      chk(rx_shift_in, 1'h0);
      cyc(80);
      ir_rx_invert = 1'b0;
      ir_en = 1'b0;
      loopback_en = 1'b1;
      modem_lvl_n = 4'h0;
      core_rts_n = 1'b0;
      core_dtr_n = 1'b0;
      tx_shift_bit = 1'b0;
      cyc(1);
      chk({tx_pin, rts_n_pin, dtr_n_pin, modem_in_n}, 7'h7F);
      chk(auto_flow_allowed, 1'h0);
      chk(rx_shift_in, 1'h0);
      tx_shift_bit = 1'b1;
      cyc(1);
      chk(rx_shift_in, 1'h1);
      loopback_en = 1'b0;
      cyc(1);
      chk({modem_in_n, rts_n_pin, dtr_n_pin, auto_flow_allowed}, 7'h01);
      modem_lvl_n = 4'hF;
      core_rts_n = 1'b1;
      core_dtr_n = 1'b1;
      cyc(2);
      sleep_en = 1'b1;
      peer_sleep_en = 1'b1;
      cyc(3);
      chk({sleeping, osc_run}, 2'h2);
      tx_hold_write = 1'b1;
      #1;
      chk(osc_run, 1'h1);
      @(negedge clk);
      tx_hold_write = 1'b0;
      chk(sleeping, 1'h0);
      cyc(3);
      chk(sleeping, 1'h1);
      int_pending = 1'b1;
      cyc(3);
      chk(sleeping, 1'h0);
      int_pending = 1'b0;
      peer_int_pending = 1'b1;
      cyc(3);
      chk(sleeping, 1'h0);
      peer_int_pending = 1'b0;
      cyc(3);
      chk(sleeping, 1'h1);
      modem_lvl_n = 4'hB;
      modem_delta = 4'h2;
      cyc(1);
      chk(sleeping, 1'h0);
      cyc(3);
      chk(sleeping, 1'h0);
      modem_delta = 4'h0;
      cyc(3);
      chk(sleeping, 1'h1);
      rx_lvl = 1'b0;
      cyc(1);
      chk(sleeping, 1'h0);
      rx_lvl = 1'b1;
      peer_rx_pin = 1'b0;
      cyc(3);
      chk(sleeping, 1'h0);
      peer_rx_pin = 1'b1;
      cyc(3);
      chk(sleeping, 1'h1);
      peer_modem_delta = 4'h8;
      cyc(3);
      chk(sleeping, 1'h0);
      peer_modem_delta = 4'h0;
      cyc(3);
      chk(sleeping, 1'h1);
      sleep_en = 1'b0;
      cyc(2);
      chk({sleeping, osc_run}, 2'h1);
      word_len = 2'h0;
      parity_en = 1'b1;
      two_stop_bits = 1'b1;
      do begin
         @(negedge clk);
         #1;
      end while (tc != 2'h1);
      @(negedge clk);
      rx_trigger_reached = 1'b1;
      cnt_on = 1'b1;
      cyc(1300);
      chk(p_ticks, 16'h0002 * (16'h0007 + 16'h0001 + 16'h0001) * 16'h0010);
      close_out();
   end
endmodule
